/* File: hw/sclr_regs.sv */
// register slice for general pins, first-byte accumulator, control line drive, selector id, line sense

// ****************************************
// one general-purpose pin: register bit, direction and read-back
// ****************************************
// used once for each implemented pin; the reserved pin 3 has no cell at all
module sclr_pin_cell
	import sclr_pkg::*;
#(
	parameter logic RESET_VALUE = 1'b0 // register bit level after reset
)
(
	input wire logic i_clock, // 50 MHz clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_clk_en, // freezes the bit while low
	input wire logic i_load, // host write to pin_io
	input wire logic i_wbit, // host write data for this pin
	input wire logic i_dir_out, // 1 output
	input wire logic i_special, // 1 special function owns the pin
	input wire logic i_special_out, // special function output level
	input wire logic i_pin_in, // sensed pin level
	output logic o_out, // pin output level
	output logic o_oe, // pin output enable
	output logic o_pullup, // pull-up enable
	output logic o_view // read-back value
);

	logic pin_bit;
	// a special function outranks the register bit so the two never fight over the pin
	wire logic drive = i_dir_out | i_special;
	assign o_oe = drive;
	assign o_out = i_special ? i_special_out : pin_bit;
	assign o_pullup = ~drive;
	// input pins are read live, so a script move sees the present level
	assign o_view = drive ? pin_bit : i_pin_in;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pin_bit <= RESET_VALUE;
		end else if (i_clk_en && i_load) begin
			pin_bit <= i_wbit;
		end
	end
endmodule // sclr_pin_cell

// ****************************************
// two-stage synchroniser for the control lines
// ****************************************
module sclr_sync2
	import sclr_pkg::*;
(
	input wire logic i_clock, // 50 MHz clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_clk_en, // freezes both stages while low
	input wire logic [7:0] i_async, // lines from the bus
	output logic [7:0] o_sync // lines safe to use in this clock domain
);

	logic [7:0] stage_meta;
	// only the second stage is read, the first may be metastable
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			stage_meta <= SCLR_READ_IDLE;
			o_sync <= SCLR_READ_IDLE;
		end else if (i_clk_en) begin
			stage_meta <= i_async;
			o_sync <= stage_meta;
		end
	end
endmodule // sclr_sync2

// ****************************************
// register slice
// ****************************************
module sclr_regs
	import sclr_pkg::*;
(
	input wire logic i_clock, // 50 MHz clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_clk_en, // freezes all state while low
	input wire logic [7:0] i_addr, // register byte offset
	input wire logic i_rd, // host read strobe
	input wire logic i_wr, // host write strobe
	input wire logic [7:0] i_wdata, // host write data
	output logic [7:0] o_rdata, // registered read data
	input wire logic [4:0] i_pin_dir_out, // per pin: 1 output (pin direction control, bits 4 and 2-0 used)
	input wire logic [4:0] i_pin_special, // per pin: 1 special function owns pin
	input wire logic [4:0] i_pin_special_out, // special function output level
	input wire logic [4:0] i_pin_in, // pin input levels
	output logic [4:0] o_pin_out, // pin output levels
	output logic [4:0] o_pin_oe, // pin output enables
	output logic [4:0] o_pin_pullup, // pull-up enables
	input wire logic i_scr_load, // script write to first-byte register
	input wire logic [7:0] i_scr_data, // script result (read-modify-write accumulator)
	input wire logic i_phase_first_byte, // first byte of an async input phase received
	input wire logic [7:0] i_bus_data, // received scsi data byte
	input wire logic i_selection_phase, // bus in selection phase
	input wire logic i_compat_bit, // compatibility control bit
	output logic [7:0] o_first_byte, // first-byte register contents
	input wire logic i_scr_line_wr, // script update of drive latch
	input wire logic [7:0] i_scr_line_data, // script drive latch value
	output logic [7:0] o_line_drive, // control line assert outputs
	input wire logic i_sel_capture, // bus-initiated selection seen
	input wire logic i_sel_two_ids, // two ids present on bus
	input wire logic [3:0] i_sel_id, // encoded selecting id
	input wire logic [7:0] i_line_state // live control lines, 1 asserted
);
	// ****************************************
	// decode
	// ****************************************
	wire logic hit_pin = (i_addr == SCLR_OFS_PIN_IO);
	wire logic hit_fb = (i_addr == SCLR_OFS_FIRST_BYTE);
	wire logic hit_drv = (i_addr == SCLR_OFS_LINE_DRIVE);
	wire logic hit_sel = (i_addr == SCLR_OFS_SELECTOR_ID);
	wire logic hit_sense = (i_addr == SCLR_OFS_LINE_SENSE);
	wire logic wr_pin = i_clk_en && i_wr && hit_pin;
	wire logic wr_drv = i_clk_en && i_wr && hit_drv;
	wire logic rd_take = i_clk_en && i_rd;

	// ****************************************
	// state and pin nets
	// ****************************************
	logic [7:0] first_byte;
	logic [7:0] line_drive;
	logic [7:0] selector;
	logic [7:0] sense_sync;
	logic [7:0] next_rdata;
	wire logic [4:0] cell_out;
	wire logic [4:0] cell_oe;
	wire logic [4:0] cell_pullup;
	wire logic [4:0] cell_view;

	// ****************************************
	// general pins
	// ****************************************
	// pin 3 is reserved: never driven, no pull-up, reads zero
	assign cell_out[3] = 1'b0;
	assign cell_oe[3] = 1'b0;
	assign cell_pullup[3] = 1'b0;
	assign cell_view[3] = 1'b0;

	sclr_pin_cell #(
		.RESET_VALUE(SCLR_PIN_RESET[0])
	) pin0_u (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(wr_pin),
		.i_wbit(i_wdata[0]),
		.i_dir_out(i_pin_dir_out[0]),
		.i_special(i_pin_special[0]),
		.i_special_out(i_pin_special_out[0]),
		.i_pin_in(i_pin_in[0]),
		.o_out(cell_out[0]),
		.o_oe(cell_oe[0]),
		.o_pullup(cell_pullup[0]),
		.o_view(cell_view[0])
	);

	sclr_pin_cell #(
		.RESET_VALUE(SCLR_PIN_RESET[1])
	) pin1_u (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(wr_pin),
		.i_wbit(i_wdata[1]),
		.i_dir_out(i_pin_dir_out[1]),
		.i_special(i_pin_special[1]),
		.i_special_out(i_pin_special_out[1]),
		.i_pin_in(i_pin_in[1]),
		.o_out(cell_out[1]),
		.o_oe(cell_oe[1]),
		.o_pullup(cell_pullup[1]),
		.o_view(cell_view[1])
	);

	sclr_pin_cell #(
		.RESET_VALUE(SCLR_PIN_RESET[2])
	) pin2_u (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(wr_pin),
		.i_wbit(i_wdata[2]),
		.i_dir_out(i_pin_dir_out[2]),
		.i_special(i_pin_special[2]),
		.i_special_out(i_pin_special_out[2]),
		.i_pin_in(i_pin_in[2]),
		.o_out(cell_out[2]),
		.o_oe(cell_oe[2]),
		.o_pullup(cell_pullup[2]),
		.o_view(cell_view[2])
	);

	// pin 4 switches the flash programming supply, so it comes out of reset low
	sclr_pin_cell #(
		.RESET_VALUE(SCLR_PIN_RESET[SCLR_FLASH_PIN_BIT])
	) pin4_u (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(wr_pin),
		.i_wbit(i_wdata[4]),
		.i_dir_out(i_pin_dir_out[4]),
		.i_special(i_pin_special[4]),
		.i_special_out(i_pin_special_out[4]),
		.i_pin_in(i_pin_in[4]),
		.o_out(cell_out[4]),
		.o_oe(cell_oe[4]),
		.o_pullup(cell_pullup[4]),
		.o_view(cell_view[4])
	);

	assign o_pin_out = cell_out & SCLR_PIN_MASK[4:0];
	assign o_pin_oe = cell_oe & SCLR_PIN_MASK[4:0];
	assign o_pin_pullup = cell_pullup & SCLR_PIN_MASK[4:0];
	wire logic [4:0] pin_view = cell_view & SCLR_PIN_MASK[4:0];

	// ****************************************
	// first byte received
	// ****************************************
	// host writes never reach this register: only capture and script paths load it
	wire logic sel_mirror = i_selection_phase && !i_compat_bit;
	wire logic first_byte_load = sel_mirror || i_phase_first_byte || i_scr_load;
	// selection mirror outranks phase capture, which outranks a script load
	wire logic [7:0] next_first_byte = sel_mirror ? i_bus_data :
		i_phase_first_byte ? i_bus_data :
		i_scr_data;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			first_byte <= SCLR_FIRST_BYTE_RESET;
		end else if (i_clk_en && first_byte_load) begin
			first_byte <= next_first_byte;
		end
	end
	assign o_first_byte = first_byte;

	// ****************************************
	// control line drive
	// ****************************************
	// the script processor wins a tie; a host write in any other cycle with i_clk_en high still loads the latch
	wire logic drive_load = (i_clk_en && i_scr_line_wr) || wr_drv;
	wire logic [7:0] next_line_drive = i_scr_line_wr ? i_scr_line_data : i_wdata;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			line_drive <= SCLR_LINE_DRIVE_RESET;
		end else if (drive_load) begin
			line_drive <= next_line_drive;
		end
	end
	assign o_line_drive = line_drive;

	// ****************************************
	// selector id
	// ****************************************
	// the id bits are kept even with one id on the bus; only the valid flag tells them apart
	wire logic [7:0] next_selector = {i_sel_two_ids, 3'h0, i_sel_id};

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			selector <= SCLR_SELECTOR_RESET;
		end else if (i_clk_en && i_sel_capture) begin
			selector <= next_selector;
		end
	end

	// ****************************************
	// line sense
	// ****************************************
	// two cycles of lag are the price of never handing a metastable bit to the host
	sclr_sync2 sense_u (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_async(i_line_state),
		.o_sync(sense_sync)
	);

	// ****************************************
	// read port
	// ****************************************
	// reserved bits read as zero here, software must still mask them
	wire logic [7:0] rd_pin = {3'h0, pin_view};
	wire logic [7:0] rd_sel = selector & {1'b1, 3'h0, SCLR_ID_MASK[3:0]};

	always_comb begin
		next_rdata = SCLR_READ_IDLE;
		if (hit_pin) begin
			next_rdata = rd_pin;
		end else if (hit_fb) begin
			next_rdata = first_byte;
		end else if (hit_drv) begin
			next_rdata = line_drive;
		end else if (hit_sel) begin
			next_rdata = rd_sel;
		end else if (hit_sense) begin
			next_rdata = sense_sync;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_rdata <= SCLR_READ_IDLE;
		end else if (rd_take) begin
			o_rdata <= next_rdata;
		end
	end
endmodule // sclr_regs

/* File: hw/sclr_pkg.sv */
// package of offsets, field positions and reset values for the scsi pin and bus-line register slice
package sclr_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] SCLR_OFS_PIN_IO = 8'h07;
	localparam logic [7:0] SCLR_OFS_FIRST_BYTE = 8'h08;
	localparam logic [7:0] SCLR_OFS_LINE_DRIVE = 8'h09;
	localparam logic [7:0] SCLR_OFS_SELECTOR_ID = 8'h0a;
	localparam logic [7:0] SCLR_OFS_LINE_SENSE = 8'h0b;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam logic [7:0] SCLR_PIN_MASK = 8'h17;
	localparam int SCLR_FLASH_PIN_BIT = 4;
	localparam int SCLR_VALID_BIT = 7;
	localparam logic [7:0] SCLR_ID_MASK = 8'h0f;
	localparam logic [4:0] SCLR_PIN_RESET = 5'h00;
	localparam logic [4:0] SCLR_DIR_RESET = 5'h10;
	localparam logic [7:0] SCLR_FIRST_BYTE_RESET = 8'h00;
	localparam logic [7:0] SCLR_LINE_DRIVE_RESET = 8'h00;
	localparam logic [7:0] SCLR_SELECTOR_RESET = 8'h00;
	localparam logic [7:0] SCLR_READ_IDLE = 8'h00;
endpackage : sclr_pkg

/* File: test/sclr_regs_monitor.sv */
// concurrent checks on the pin and bus-line register slice
module sclr_regs_monitor(
	input wire logic i_clock, i_rst_n, i_clk_en, i_rd, i_wr, i_scr_load, i_phase_first_byte,
	input wire logic i_selection_phase, i_compat_bit,
	input wire logic [7:0] i_addr, i_wdata, o_rdata, i_scr_data, i_bus_data, o_first_byte, o_line_drive, i_line_state,
	input wire logic [4:0] i_pin_dir_out, i_pin_special, o_pin_out, o_pin_oe, o_pin_pullup
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire mirror = i_selection_phase && !i_compat_bit;
	wire quiet = !mirror && !i_phase_first_byte;
	chk_pull_up: assert property ((~i_pin_dir_out & ~i_pin_special & ~o_pin_pullup & 5'h17) == 5'h00)
		else $error("input pin without pull-up");
	chk_pin_drive: assert property (i_clk_en && i_wr && i_addr == 8'h07 |=> (({3'h0, o_pin_out} ^ $past(i_wdata))
		& {3'h0, o_pin_oe & ~i_pin_special} & 8'h17) == 8'h00) else $error("output pin level differs");
	chk_reset_zero: assert property (disable iff (1'b0) !i_rst_n |=> o_line_drive == 8'h00 && o_first_byte == 8'h00)
		else $error("reset value wrong");
	chk_first_capture: assert property (mirror || i_phase_first_byte |=> o_first_byte == $past(i_bus_data))
		else $error("bus byte not captured");
	chk_script_load: assert property (i_scr_load && quiet |=> o_first_byte == $past(i_scr_data))
		else $error("script load lost");
	chk_host_ignored: assert property (i_wr && i_addr == 8'h08 && !i_scr_load && quiet |=> $stable(o_first_byte))
		else $error("host write changed first byte");
	chk_line_latch: assert property (i_clk_en && i_wr && i_addr == 8'h09 |=> o_line_drive == $past(i_wdata))
		else $error("drive latch not written");
	chk_sense_lag: assert property (i_rd && i_addr == 8'h0b |=> o_rdata == $past(i_line_state, 3))
		else $error("sense read differs");
endmodule // sclr_regs_monitor
bind sclr_regs sclr_regs_monitor mon_u (.*);

/* File: test/sclr_pin_model.sv */
// far side of the general pins: external drivers, pull-ups and floating pins
module sclr_pin_model(
	input wire logic i_clock, // clock
	input wire logic [4:0] i_oe, i_out, i_pullup, i_ext_en, i_ext_val, // both drivers
	output logic [4:0] o_level // resolved pin levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] last = 5'h00;
	always @(posedge i_clock) last <= o_level;
	// outside parts let go of a pin that this device drives, so no pin has two drivers
	// pins 1 and 0 stand for an eeprom's clock and data line, driven only as levels here
	// a pin nobody holds or pulls up flips each cycle so an unknown cannot pass for a level
	always_comb o_level = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext_val) | (~i_ext_en & (i_pullup | ~last))));
endmodule // sclr_pin_model

/* File: test/testbench.sv */
// self-checking bench for the pin and bus-line register slice
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 0, i_rst_n = 0, i_rd = 0, i_wr = 0, i_scr_load = 0, i_phase_first_byte = 0, i_selection_phase = 0;
	logic i_compat_bit = 1, i_sel_capture = 0, i_sel_two_ids = 0, rd_q = 0, i_clk_en = 1;
	logic [7:0] i_addr = 0, i_wdata = 0, i_scr_data = 0, i_bus_data = 0, i_line_state = 0, o_rdata, o_first_byte, o_line_drive, r;
	logic [4:0] dir = 5'h10, en = 0, v = 0, pin, o_pin_out, o_pin_oe, o_pin_pullup;
	logic [3:0] i_sel_id = 0;
	logic [15:0] q[$];
	int bad_count = 0, compares = 0, cycles = 0;
	sclr_regs dut_u (.i_pin_dir_out(dir), .i_pin_special(5'h00), .i_pin_special_out(5'h00),
		.i_pin_in(pin), .i_scr_line_wr(1'b0), .i_scr_line_data(8'h00), .*);
	sclr_pin_model pm_u (.i_clock, .i_oe(o_pin_oe), .i_out(o_pin_out), .i_pullup(o_pin_pullup), .i_ext_en(en),
		.i_ext_val(v), .o_level(pin));
	always #10 i_clock = ~i_clock;
	task automatic end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value o_rdata expected %h seen %h", exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clock) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
		@(posedge i_clock) i_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e, m = 8'hff);
		q.push_back({m, e & m});
		@(posedge i_clock) begin i_rd <= 1; i_addr <= a; end
		@(posedge i_clock) i_rd <= 0;
	endtask
	always @(posedge i_clock) begin
		rd_q <= i_rd;
		cycles <= cycles + 1;
		if (cycles == 3000) begin bad_count++; end_of_test; end
	end
	// the answer lands one edge after the read, so it is taken off the queue half a cycle later
	always @(negedge i_clock) if (rd_q) begin chk(o_rdata & q[0][15:8], q[0][7:0]); void'(q.pop_front()); end
	initial begin
		void'($urandom(32'hbf6a));
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1;
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h07, 8'h07);
		rd(8'h0c, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			r = 8'($urandom);
			@(posedge i_clock) begin dir <= 5'($urandom); en <= 5'($urandom); v <= 5'($urandom); i_line_state <= ~r; end
			wr(8'h07, r);
			rd(8'h07, {3'h0, ((dir & r[4:0]) | (~dir & (~en | v))) & 5'h17});
			rd(8'h0b, ~r);
			wr(8'h09, r); // host write loads the latch; the script write input is tied low here
			rd(8'h09, r);
			@(posedge i_clock) i_clk_en <= 0;
			wr(8'h09, ~r);
			@(posedge i_clock) i_clk_en <= 1;
			rd(8'h09, r); // a write while frozen is lost
			@(posedge i_clock) begin i_scr_load <= 1; i_scr_data <= r; end
			@(posedge i_clock) i_scr_load <= 0;
			wr(8'h08, ~r);
			rd(8'h08, r);
			@(posedge i_clock) begin i_phase_first_byte <= 1; i_bus_data <= ~r; end
			// the selection phase mirrors the bus byte while the compatibility bit is clear
			@(posedge i_clock) begin i_phase_first_byte <= 0; i_selection_phase <= 1; i_compat_bit <= 0; end
			rd(8'h08, ~r);
			@(posedge i_clock) begin i_selection_phase <= 0; i_compat_bit <= 1; i_sel_capture <= 1; i_sel_two_ids <= r[7];
				i_sel_id <= r[3:0]; end
			@(posedge i_clock) i_sel_capture <= 0;
			rd(8'h0a, {r[7], 3'h0, r[3:0]}, {4'hf, {4{r[7]}}});
			$display("pass %0d done", i);
		end
		end_of_test;
	end
endmodule // testbench
